// [common/tcc_pkg.sv]
// Constants, codes and helpers shared by the timer capture and compare blocks.
// Assumes an 18-bit count bus from an external basic timer.
package tcc_pkg;
  // ----------------------------------------------------------------------------
  // Widths and offsets
  // ----------------------------------------------------------------------------
  localparam int   CNT_W      = 18;
  localparam logic OFS_CTRL   = 1'h0;
  localparam logic OFS_DATA   = 1'h1;
  localparam int   CAP_CTRL_W = 5;
  localparam int   CMP_CTRL_W = 6;
  typedef logic [CNT_W-1:0] tcc_count_type;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int CAP_EN_BIT   = 0;
  localparam int CAP_INT_BIT  = 1;
  localparam int CAP_MODE_LSB = 2;
  localparam int CMP_EN_BIT   = 0;
  localparam int CMP_INT_BIT  = 1;
  localparam int CMP_MODE_LSB = 2;
  localparam int CMP_TWO_BIT  = 4;
  localparam int CMP_OUT_BIT  = 5;
  localparam int CMP_LVL_BIT  = 6;

  // ----------------------------------------------------------------------------
  // Reset values and mode codes
  // ----------------------------------------------------------------------------
  localparam logic [CAP_CTRL_W-1:0] CAP_CTRL_RST = 5'h00;
  localparam logic [CMP_CTRL_W-1:0] CMP_CTRL_RST = 6'h00;
  localparam tcc_count_type         DATA_RST     = 18'h0_0000;
  localparam logic [2:0] CAP_FALL   = 3'h2;
  localparam logic [2:0] CAP_RISE   = 3'h3;
  localparam logic [2:0] CAP_LOW    = 3'h4;
  localparam logic [2:0] CAP_HIGH   = 3'h5;
  localparam logic [2:0] CMP_SET    = 3'h1;
  localparam logic [2:0] CMP_CLR    = 3'h2;
  localparam logic [2:0] CMP_TOG    = 3'h3;
  localparam logic [2:0] CMP_PWM_HI = 3'h5;
  localparam logic [2:0] CMP_PWM_LO = 3'h6;
  localparam logic [2:0] CMP_PWM_H2 = 3'h7;

  // Any read or write that selects a unit
  function automatic logic tcc_access(input logic sel, input logic rd, input logic wr);
    return sel & (rd | wr);
  endfunction : tcc_access
endpackage : tcc_pkg

// [common/tcc_cap_if.sv]
// Link between the register front end and the capture unit.
// Assumes one clock domain; the front end decodes, the unit stores.
`timescale 1ns/100ps
`default_nettype none
interface tcc_cap_if;
  import tcc_pkg::*;
  logic                  access;
  logic                  wr_ctrl;
  tcc_count_type         wdata;
  tcc_count_type         count;
  logic [CAP_CTRL_W-1:0] ctrl;
  tcc_count_type         captured;
  logic                  irq;
  modport host (output access, wr_ctrl, wdata, count, input ctrl, captured, irq);
  modport unit (input access, wr_ctrl, wdata, count, output ctrl, captured, irq);
endinterface : tcc_cap_if
`default_nettype wire

// [hw/tcc_capture.sv]
// Capture unit: latches the timer count on a chosen trigger condition.
// Assumes the front end drives access and control writes from the bus.
`timescale 1ns/100ps
`default_nettype none
module tcc_capture
  import tcc_pkg::*;
(
  input  wire logic ref_clk,  // System clock
  input  wire logic rst_b,    // Async reset, active low
  input  wire logic trig,     // External trigger pin
  tcc_cap_if.unit   bus       // Register side
);
  logic       trig_meta;
  logic       trig_sync;
  logic       trig_prev;
  logic [2:0] mode;
  logic       rise;
  logic       fall;
  logic       trig_hit;
  logic       capture;

  // ----------------------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------------------
  // Edges seen only after the second stage, never on the metastable one
  assign mode     = bus.ctrl[CAP_MODE_LSB+:3];
  assign rise     = trig_sync & ~trig_prev;
  assign fall     = ~trig_sync & trig_prev;
  assign trig_hit = (mode == CAP_FALL) ? fall :
                    (mode == CAP_RISE) ? rise :
                    (mode == CAP_LOW)  ? ~trig_sync :
                    (mode == CAP_HIGH) ? trig_sync :
                    (mode[2:1] == 2'h3) ? (rise | fall) : 1'h0;
  assign capture  = bus.ctrl[CAP_EN_BIT] & trig_hit;

  // Synchroniser and previous sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_meta <= 1'h0;
      trig_sync <= 1'h0;
      trig_prev <= 1'h0;
    end else begin
      trig_meta <= trig;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  // Control, flag and captured value; a flag set beats a clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.ctrl     <= CAP_CTRL_RST;
      bus.irq      <= 1'h0;
      bus.captured <= DATA_RST;
    end else begin
      if (bus.wr_ctrl) begin
        bus.ctrl <= bus.wdata[CAP_CTRL_W-1:0];
      end else if (capture) begin
        bus.ctrl[CAP_EN_BIT] <= 1'h0;
      end
      bus.irq <= (capture & bus.ctrl[CAP_INT_BIT]) | (bus.irq & ~bus.access);
      if (capture) begin
        bus.captured <= bus.count;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_cap_load;
    capture |=> bus.captured == $past(bus.count);
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capture value wrong");
  property p_cap_disarm;
    capture && !bus.wr_ctrl |=> !bus.ctrl[CAP_EN_BIT] && !capture;
  endproperty
  a_cap_disarm: assert property (p_cap_disarm) else $error("capture not disarmed");
  property p_cap_irq;
    capture && bus.ctrl[CAP_INT_BIT] |=> bus.irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture flag missing");
  property p_cap_clear;
    bus.access && !(capture && bus.ctrl[CAP_INT_BIT]) |=> !bus.irq;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture flag kept");
  c_cap_rise: cover property (capture && mode == CAP_RISE);
endmodule : tcc_capture
`default_nettype wire

// [hw/tcc_top.sv]
// Timer capture and compare pair behind a small processor register port.
// Assumes an external basic timer drives the count and the processor
// selects one unit at a time with a one-bit offset.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Both units use the external 18-bit timer count; no counter inside.
// - Armed capture with its trigger condition loads the present count.
// - Capture arm bit 0 resets low and clears itself after a capture.
// - Capture interrupt enable bit 1 lets each capture raise the flag.
// - Any access to either capture register clears the capture flag.
// - Capture mode bits 2-4 pick off, fall, rise, low, high or both edges.
// - Captured value at offset 1 is read only and holds 18 bits.
// - Compare raises an event when compare value equals the count.
// - Compare bit 0 enables logic, bit 1 interrupt; both reset low.
// - Compare flag set on enabled match events, cleared by any compare access.
// - Single-edge modes on match: hold, set, clear or toggle the output.
// - Mode bit 4 set acts twice per period: at zero and at match.
// - Two-edge codes: 100 hold, 101/111 high then low, 110 reversed.
// - Bit 5 drives the pin, read-only bit 6 shows the output level.
// - Compare value at offset 1 is 18-bit read and write.
// - Unused upper control bits read zero and ignore writes.
module tcc_top
  import tcc_pkg::*;
(
  input  wire logic          ref_clk,      // System clock
  input  wire logic          rst_b,        // Async reset, active low
  input  wire tcc_count_type timer_count,  // Count from basic timer
  input  wire logic          cap_trig,     // Capture trigger pin
  input  wire logic          reg_cap_sel,  // Capture unit selected
  input  wire logic          reg_cmp_sel,  // Compare unit selected
  input  wire logic          reg_addr,     // Register offset
  input  wire logic          reg_wr,       // Write strobe
  input  wire logic          reg_rd,       // Read strobe
  input  wire tcc_count_type reg_wdata,    // Write data
  output var  tcc_count_type reg_rdata,    // Read data, next cycle
  output var  logic          cap_irq,      // Capture flag
  output var  logic          cmp_irq,      // Compare flag
  output var  logic          cmp_pin,      // Compare pin level
  output var  logic          cmp_pin_oe_b  // Pin enable, low drives
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  tcc_cap_if cap_bus ();

  logic [CMP_CTRL_W-1:0] cmp_ctrl;
  tcc_count_type         compare_value;
  logic                  compare_output_level;
  logic                  match_q;
  logic                  zero_q;
  logic                  cmp_flag;

  logic                  cmp_access;
  logic                  cmp_wr_ctrl;
  logic                  cmp_wr_data;
  logic                  match;
  logic                  zero;
  logic                  match_ev;
  logic                  zero_ev;
  logic [2:0]            cmp_mode;
  logic                  two_edge_output_select;
  logic                  match_level;
  logic                  zero_level;
  logic                  next_level;
  logic                  next_cmp_flag;
  tcc_count_type         cap_ctrl_word;
  tcc_count_type         cmp_ctrl_word;
  tcc_count_type         cap_word;
  tcc_count_type         cmp_word;
  tcc_count_type         next_rdata;

  // ----------------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------------
  // Both strobes together count as a write plus a read
  assign cap_bus.access  = tcc_access(reg_cap_sel, reg_rd, reg_wr);
  assign cap_bus.wr_ctrl = reg_cap_sel & reg_wr & (reg_addr == OFS_CTRL);
  assign cap_bus.wdata   = reg_wdata;
  assign cap_bus.count   = timer_count;
  assign cmp_access      = tcc_access(reg_cmp_sel, reg_rd, reg_wr);
  assign cmp_wr_ctrl     = reg_cmp_sel & reg_wr & (reg_addr == OFS_CTRL);
  assign cmp_wr_data     = reg_cmp_sel & reg_wr & (reg_addr == OFS_DATA);

  // ----------------------------------------------------------------------------
  // Capture unit
  // ----------------------------------------------------------------------------
  tcc_capture u_capture (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .trig    (cap_trig),
    .bus     (cap_bus)
  );

  assign cap_irq = cap_bus.irq;

  // ----------------------------------------------------------------------------
  // Compare detection
  // ----------------------------------------------------------------------------
  // Equality looked at each cycle; prescaled timers hold a value for many
  // cycles, so only the first cycle of a match counts
  assign match    = (compare_value == timer_count);
  assign zero     = (timer_count == DATA_RST);
  assign match_ev = cmp_ctrl[CMP_EN_BIT] & match & ~match_q;
  assign zero_ev  = cmp_ctrl[CMP_EN_BIT] & zero & ~zero_q;

  // Output level decode
  assign cmp_mode               = cmp_ctrl[CMP_MODE_LSB+:3];
  assign two_edge_output_select = cmp_ctrl[CMP_TWO_BIT];
  assign match_level = (cmp_mode == CMP_SET)    ? 1'h1 :
                       (cmp_mode == CMP_PWM_HI) ? 1'h1 :
                       (cmp_mode == CMP_PWM_H2) ? 1'h1 :
                       (cmp_mode == CMP_CLR)    ? 1'h0 :
                       (cmp_mode == CMP_PWM_LO) ? 1'h0 :
                       (cmp_mode == CMP_TOG)    ? ~compare_output_level :
                       compare_output_level;
  assign zero_level  = (cmp_mode == CMP_PWM_HI) ? 1'h0 :
                       (cmp_mode == CMP_PWM_H2) ? 1'h0 :
                       (cmp_mode == CMP_PWM_LO) ? 1'h1 :
                       compare_output_level;
  // A zero compare value hits both at once; the match action wins
  assign next_level  = match_ev ? match_level :
                       (zero_ev & two_edge_output_select) ? zero_level :
                       compare_output_level;

  // Flag: a new event beats a clearing access in the same cycle
  assign next_cmp_flag = (match_ev & cmp_ctrl[CMP_INT_BIT]) |
                         (cmp_flag & ~cmp_access);

  // ----------------------------------------------------------------------------
  // Compare registers
  // ----------------------------------------------------------------------------
  // Control state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_ctrl             <= CMP_CTRL_RST;
      compare_output_level <= 1'h0;
      match_q              <= 1'h0;
      zero_q               <= 1'h0;
      cmp_flag             <= 1'h0;
    end else begin
      if (cmp_wr_ctrl) begin
        cmp_ctrl <= reg_wdata[CMP_CTRL_W-1:0];
      end
      compare_output_level <= next_level;
      match_q              <= match;
      zero_q               <= zero;
      cmp_flag             <= next_cmp_flag;
    end
  end

  // Compare value, full width read and write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_value <= DATA_RST;
    end else if (cmp_wr_data) begin
      compare_value <= reg_wdata;
    end
  end

  // Pin: level always kept, driven only when enabled
  assign cmp_pin      = compare_output_level;
  assign cmp_pin_oe_b = ~cmp_ctrl[CMP_OUT_BIT];
  assign cmp_irq      = cmp_flag;

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // Upper bits zero-filled by the casts
  assign cap_ctrl_word = tcc_count_type'(cap_bus.ctrl);
  assign cmp_ctrl_word = tcc_count_type'({compare_output_level, cmp_ctrl});
  assign cap_word      = (reg_addr == OFS_CTRL) ? cap_ctrl_word : cap_bus.captured;
  assign cmp_word      = (reg_addr == OFS_CTRL) ? cmp_ctrl_word : compare_value;
  // Nothing selected reads as zero
  assign next_rdata    = reg_cap_sel ? cap_word :
                         reg_cmp_sel ? cmp_word : DATA_RST;

  // Read data held until the next read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= DATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_cmp_single;
    match_ev |=> !match_ev;
  endproperty
  a_cmp_single: assert property (p_cmp_single) else $error("repeated match event");

  property p_cmp_event;
    cmp_ctrl[CMP_EN_BIT] && match && !match_q |-> match_ev;
  endproperty
  a_cmp_event: assert property (p_cmp_event) else $error("match event missed");

  property p_cmp_off;
    !cmp_ctrl[CMP_EN_BIT] |-> !match_ev && !zero_ev;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("event while disabled");

  property p_cmp_irq;
    match_ev && cmp_ctrl[CMP_INT_BIT] |=> cmp_irq;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare flag missing");

  property p_cmp_clear;
    cmp_access && !(match_ev && cmp_ctrl[CMP_INT_BIT]) |=> !cmp_irq;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag kept");

  property p_cmp_set;
    match_ev && cmp_mode == CMP_SET |=> compare_output_level;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("set mode failed");

  property p_cmp_toggle;
    match_ev && cmp_mode == CMP_TOG |=> compare_output_level != $past(compare_output_level);
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("toggle failed");

  property p_cmp_hold;
    !match_ev && !(zero_ev && two_edge_output_select) |=> $stable(compare_output_level);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("level moved unasked");

  property p_cmp_pwm_zero;
    zero_ev && !match_ev && cmp_mode == CMP_PWM_LO |=> compare_output_level;
  endproperty
  a_cmp_pwm_zero: assert property (p_cmp_pwm_zero) else $error("zero action wrong");

  property p_cmp_pwm_match;
    match_ev && cmp_mode == CMP_PWM_H2 |=> compare_output_level;
  endproperty
  a_cmp_pwm_match: assert property (p_cmp_pwm_match) else $error("match action wrong");

  property p_cmp_upper;
    reg_rd && reg_cmp_sel && reg_addr == OFS_CTRL |=> reg_rdata[CNT_W-1:7] == '0;
  endproperty
  a_cmp_upper: assert property (p_cmp_upper) else $error("upper bits not zero");

  property p_cap_read;
    reg_rd && reg_cap_sel && reg_addr == OFS_DATA |=> reg_rdata == $past(cap_bus.captured);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("captured read wrong");

  // Clear mode forces low
  property p_cmp_clr;
    match_ev && cmp_mode == CMP_CLR
      |=> !compare_output_level;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("clear mode failed");

  // Zero idle in one-edge modes
  property p_cmp_one_edge;
    zero_ev && !match_ev && !two_edge_output_select
      |=> $stable(compare_output_level);
  endproperty
  a_cmp_one_edge: assert property (p_cmp_one_edge) else $error("zero in single mode");

  // Mode 101 low at zero
  property p_cmp_hi_zero;
    zero_ev && !match_ev && cmp_mode == CMP_PWM_HI
      |=> !compare_output_level;
  endproperty
  a_cmp_hi_zero: assert property (p_cmp_hi_zero) else $error("zero low failed");

  // Mode 110 low at match
  property p_cmp_lo_match;
    match_ev && cmp_mode == CMP_PWM_LO
      |=> !compare_output_level;
  endproperty
  a_cmp_lo_match: assert property (p_cmp_lo_match) else $error("match low failed");

  // Level bit reads back
  property p_cmp_level_rd;
    reg_rd && reg_cmp_sel && !reg_cap_sel && reg_addr == OFS_CTRL
      |=> reg_rdata[CMP_LVL_BIT] == $past(compare_output_level);
  endproperty
  a_cmp_level_rd: assert property (p_cmp_level_rd) else $error("level bit wrong");

  // Value write stores all bits
  property p_cmp_value_wr;
    cmp_wr_data
      |=> compare_value == $past(reg_wdata);
  endproperty
  a_cmp_value_wr: assert property (p_cmp_value_wr) else $error("value write lost");

  // Value reads back whole
  property p_cmp_value_rd;
    reg_rd && reg_cmp_sel && !reg_cap_sel && reg_addr == OFS_DATA
      |=> reg_rdata == $past(compare_value);
  endproperty
  a_cmp_value_rd: assert property (p_cmp_value_rd) else $error("value read wrong");

  // Control keeps its bits
  property p_cmp_ctrl_wr;
    cmp_wr_ctrl
      |=> cmp_ctrl == $past(reg_wdata[CMP_CTRL_W-1:0]);
  endproperty
  a_cmp_ctrl_wr: assert property (p_cmp_ctrl_wr) else $error("control write lost");

  // Capture upper bits zero
  property p_cap_upper;
    reg_rd && reg_cap_sel && reg_addr == OFS_CTRL
      |=> reg_rdata[CNT_W-1:CAP_CTRL_W] == '0;
  endproperty
  a_cap_upper: assert property (p_cap_upper) else $error("capture upper bits set");

  // Flag held until access
  property p_cmp_irq_keep;
    cmp_irq && !cmp_access
      |=> cmp_irq;
  endproperty
  a_cmp_irq_keep: assert property (p_cmp_irq_keep) else $error("compare flag lost");

  // Flag only from events
  property p_cmp_irq_src;
    !cmp_irq && !(match_ev && cmp_ctrl[CMP_INT_BIT])
      |=> !cmp_irq;
  endproperty
  a_cmp_irq_src: assert property (p_cmp_irq_src) else $error("compare flag unasked");

  // ----------------------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------------------
  c_cmp_toggle: cover property (match_ev && cmp_mode == CMP_TOG);
  c_cmp_pwm:    cover property (zero_ev && cmp_mode == CMP_PWM_HI ##[1:300] match_ev);
  c_cmp_clear:  cover property (cmp_irq && cmp_access);
  c_cap_clear:  cover property (cap_irq && cap_bus.access);

endmodule : tcc_top
`default_nettype wire

// [dv/tcc_timer_model.sv]
// Basic timer stand-in: an 18-bit up counter that wraps after a limit.
// Assumes the bench drives run and limit just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_model
  import tcc_pkg::*;
(
  input  wire logic          ref_clk,  // System clock
  input  wire logic          rst_b,    // Async reset, active low
  input  wire logic          run,      // Count enable
  input  wire tcc_count_type limit,    // Last count before wrap
  output var  tcc_count_type count     // Full count to both units
);
  // Wrap on >= so a limit lowered mid-period cannot run away
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 18'h0_0000;
    end else if (run) begin
      count <= (count >= limit) ? 18'h0_0000 : count + 18'h0_0001;
    end
  end
endmodule : tcc_timer_model
`default_nettype wire

// [dv/tb_timer_capture_compare.sv]
// Self-checking bench for the capture and compare pair.
// Assumes a reference model here, updated on the same edges as the design.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_capture_compare;
  import tcc_pkg::*;
  logic          ref_clk, rst_b, cap_trig, run;
  logic          reg_cap_sel, reg_cmp_sel, reg_addr, reg_wr, reg_rd;
  tcc_count_type reg_wdata, reg_rdata, tcnt, limit, m_cv, m_pv, m_rd, val;
  logic          cap_irq, cmp_irq, cmp_pin, cmp_pin_oe_b;
  logic [2:0]    m_tr;
  logic [4:0]    m_cc;
  logic [5:0]    m_pc;
  logic          m_ci, m_pi, m_lv, m_pm, m_pz, cap_acc, cmp_acc, cap_hit, mev, zev;
  logic [15:0]   rs;
  int            mismatches, tests_run;

  tcc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .timer_count(tcnt),
    .cap_trig(cap_trig), .reg_cap_sel(reg_cap_sel), .reg_cmp_sel(reg_cmp_sel),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cap_irq(cap_irq), .cmp_irq(cmp_irq),
    .cmp_pin(cmp_pin), .cmp_pin_oe_b(cmp_pin_oe_b));
  tcc_timer_model timer (.ref_clk(ref_clk), .rst_b(rst_b), .run(run), .limit(limit),
    .count(tcnt));

  // ----------------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------------
  function automatic logic nxt_lv(input logic [2:0] md, input logic me, input logic ze,
                                  input logic lv);
    if (me) begin
      case (md)
        3'h1, 3'h5, 3'h7: return 1'b1;
        3'h2, 3'h6:       return 1'b0;
        3'h3:             return ~lv;
        default:          return lv;
      endcase
    end
    if (ze && md[1:0] != 2'b00) return (md == 3'h6);
    return lv;
  endfunction : nxt_lv

  // Decisions use the synced sample against its history, never the raw pin
  always_comb begin
    cap_acc = reg_cap_sel & (reg_rd | reg_wr);
    cmp_acc = reg_cmp_sel & (reg_rd | reg_wr);
    case (m_cc[4:2])
      3'h2:       cap_hit = m_tr[2] & ~m_tr[1];
      3'h3:       cap_hit = ~m_tr[2] & m_tr[1];
      3'h4:       cap_hit = ~m_tr[1];
      3'h5:       cap_hit = m_tr[1];
      3'h6, 3'h7: cap_hit = m_tr[2] ^ m_tr[1];
      default:    cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit & m_cc[0];
    mev = m_pc[0] & (m_pv == tcnt) & ~m_pm;
    zev = m_pc[0] & m_pc[4] & (tcnt == 18'h0_0000) & ~m_pz;
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {m_tr, m_cc, m_pc, m_ci, m_pi, m_lv, m_pm, m_pz} <= '0;
      {m_cv, m_pv, m_rd} <= '0;
    end else begin
      m_tr <= {m_tr[1:0], cap_trig};
      m_pm <= (m_pv == tcnt);
      m_pz <= (tcnt == 18'h0_0000);
      if (cap_hit) m_cv <= tcnt;
      if (reg_cap_sel && reg_wr && !reg_addr) m_cc <= reg_wdata[4:0];
      else if (cap_hit) m_cc[0] <= 1'b0;
      m_ci <= (cap_hit & m_cc[1]) | (m_ci & ~cap_acc);
      m_pi <= (mev & m_pc[1]) | (m_pi & ~cmp_acc);
      m_lv <= nxt_lv(m_pc[4:2], mev, zev, m_lv);
      if (reg_cmp_sel && reg_wr && !reg_addr) m_pc <= reg_wdata[5:0];
      if (reg_cmp_sel && reg_wr && reg_addr) m_pv <= reg_wdata;
      if (reg_rd) begin
        if (reg_cap_sel) m_rd <= reg_addr ? m_cv : {13'h0_000, m_cc};
        else if (reg_cmp_sel) m_rd <= reg_addr ? m_pv : {11'h000, m_lv, m_pc};
        else m_rd <= 18'h0_0000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------------
  task automatic chk(input tcc_count_type seen, input tcc_count_type exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Every output compared each cycle, settled at the falling edge
  always @(negedge ref_clk) begin
    if (rst_b) begin
      chk(reg_rdata, m_rd, "read data");
      chk({17'h0_0000, cap_irq}, {17'h0_0000, m_ci}, "capture flag");
      chk({17'h0_0000, cmp_pin}, {17'h0_0000, m_lv}, "pin level");
      chk({17'h0_0000, cmp_pin_oe_b}, {17'h0_0000, ~m_pc[5]}, "pin enable");
      // Only match events raise the compare flag, in every mode
      chk({17'h0_0000, cmp_irq}, {17'h0_0000, m_pi}, "compare flag");
    end
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // One access per call; strobes drop on the following edge
  task automatic acc(input logic [1:0] sel, input logic adr, input logic wr,
                     input tcc_count_type d);
    @(posedge ref_clk);
    {reg_cap_sel, reg_cmp_sel, reg_addr, reg_wr, reg_rd, reg_wdata} <= {sel, adr, wr, ~wr, d};
    @(posedge ref_clk);
    {reg_cap_sel, reg_cmp_sel, reg_wr, reg_rd} <= 4'h0;
  endtask : acc

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Watchdog sized well above the roughly 1700 cycles the tests need
  initial begin
    #(20000 * 5);
    mismatches++;
    $display("Watchdog expired");
    wrap_up;
  end

  initial begin
    {rst_b, cap_trig, run, reg_cap_sel, reg_cmp_sel, reg_addr, reg_wr, reg_rd} = '0;
    reg_wdata = '0;
    limit = 18'h0_0020;
    rs = 16'h387C;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, reserved bits, read-only places and an unselected read
    acc(2'b10, 0, 0, 18'h0_0000);
    acc(2'b01, 0, 0, 18'h0_0000);
    acc(2'b10, 0, 1, 18'h3_FFFC);
    acc(2'b10, 0, 0, 18'h0_0000);
    acc(2'b10, 0, 1, 18'h0_0000);
    acc(2'b01, 0, 1, 18'h3_FFE0);
    acc(2'b01, 0, 0, 18'h0_0000);
    rs = nxt(rs);
    acc(2'b01, 1, 1, {2'b11, rs});
    acc(2'b01, 1, 0, 18'h0_0000);
    acc(2'b10, 1, 1, {2'b10, rs});
    acc(2'b10, 1, 0, 18'h0_0000);
    acc(2'b00, 0, 0, 18'h0_0000);
    $display("Test registers done");
    // Every capture mode, armed then triggered by two pin changes
    run <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      @(posedge ref_clk) cap_trig <= (m == 2 || m == 4);
      repeat (4) @(posedge ref_clk);
      rs = nxt(rs);
      acc(2'b10, 0, 1, {13'h0_000, m[2:0], rs[0], 1'b1});
      repeat (1 + rs[3:1]) @(posedge ref_clk);
      cap_trig <= ~cap_trig;
      repeat (2 + rs[6:4]) @(posedge ref_clk);
      cap_trig <= ~cap_trig;
      repeat (6) @(posedge ref_clk);
      acc(2'b10, 0, 0, 18'h0_0000);
      acc(2'b10, 1, 1, {2'b01, rs});
      acc(2'b10, 1, 0, 18'h0_0000);
    end
    $display("Test capture done");
    // Every compare mode over several timer periods
    for (int m = 0; m < 8; m++) begin
      rs = nxt(rs);
      limit <= 18'h0_0014 + rs[4:0];
      val = 18'h0_0001 + rs[8:5];
      acc(2'b01, 1, 1, val);
      acc(2'b01, 0, 1, {12'h000, 1'b1, m[2:0], rs[9], 1'b1});
      repeat (110) @(posedge ref_clk);
      acc(2'b01, 1, 0, 18'h0_0000);
      repeat (60) @(posedge ref_clk);
      acc(2'b01, 0, 0, 18'h0_0000);
    end
    $display("Test compare done");
    wrap_up;
  end
endmodule : tb_timer_capture_compare
`default_nettype wire
